// ===== hw/tlim_pkg.sv
/*
 * Constants, register map and carrier types of the two-level interrupt masking block.
 * Assumes a 32-bit AXI4-Lite register bus with one aligned word per register.
 */
`default_nettype none

package tlim_pkg;

	// ==========================================================================
	// Register indices as printed, byte address is four times the index
	// ==========================================================================
	localparam logic [31:0] IDX_SERIAL_IRQ_STATUS = 32'h0b00008a;
	localparam logic [31:0] IDX_SYSTEM_IRQ_MASK = 32'h0b00008c;
	localparam logic [31:0] IDX_TOUCH_IRQ_MASK = 32'h0b00008e;
	localparam logic [31:0] IDX_AUDIO_IRQ_MASK = 32'h0b000090;
	localparam logic [31:0] IDX_KEYBOARD_IRQ_MASK = 32'h0b000092;
	localparam logic [31:0] IDX_GPIO_IRQ_MASK = 32'h0b000094;
	localparam logic [31:0] IDX_SERIAL_IRQ_MASK = 32'h0b000096;
	localparam logic [31:0] IDX_BATTERY_IRQ_ROUTE = 32'h0b000098;
	localparam logic [31:0] IDX_SOFTWARE_IRQ_SET = 32'h0b00009a;
	localparam logic [31:0] ADDR_STRIDE = 32'h00000004;

	// ==========================================================================
	// Implemented (writable or defined) bits of each register
	// ==========================================================================
	localparam logic [15:0] BITS_SERIAL = 16'h3fff;
	localparam logic [15:0] BITS_SYSTEM = 16'h3fff;
	localparam logic [15:0] BITS_TOUCH = 16'h001f;
	localparam logic [15:0] BITS_AUDIO = 16'h000f;
	localparam logic [15:0] BITS_KEYBOARD = 16'h001f;
	localparam logic [15:0] BITS_GPIO = 16'h2fff;
	localparam logic [15:0] BITS_ROUTE = 16'h0001;
	localparam logic [15:0] BITS_SOFT = 16'h0001;
	localparam logic [15:0] RESET_VALUE = 16'h0000;

	// ==========================================================================
	// Level-1 bit positions
	// ==========================================================================
	localparam int unsigned L1_TOUCH_SUSPEND = 13;
	localparam int unsigned L1_KEYBOARD_SUSPEND = 12;
	localparam int unsigned L1_SOFTWARE = 11;
	localparam int unsigned L1_BUS_ERROR = 10;
	localparam int unsigned L1_SERIAL = 9;
	localparam int unsigned L1_GPIO = 8;
	localparam int unsigned L1_KEYBOARD = 7;
	localparam int unsigned L1_AUDIO = 6;
	localparam int unsigned L1_TOUCH = 5;
	localparam int unsigned L1_PC_CARD = 4;
	localparam int unsigned L1_EXT_TIMER = 3;
	localparam int unsigned L1_RTC_LONG = 2;
	localparam int unsigned L1_POWER = 1;
	localparam int unsigned L1_BATTERY = 0;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Peripheral request levels, held high until the peripheral clears its event
	typedef struct packed {
		logic [13:0] serial;             // Serial and debug-serial events
		logic [4:0] touch;               // Touch-panel events
		logic [3:0] audio;               // Audio events
		logic [4:0] keyboard;            // Keyboard events
		logic [13:0] gpio;               // Carrier-detect pin and general-purpose pins
		logic touch_suspend_irq;         // Touch panel in suspend mode
		logic keyboard_suspend_irq;      // Keyboard in suspend mode
		logic bus_error_irq;             // Bus error
		logic pc_card_irq;               // PC-card
		logic extended_timer_irq;        // Extended timer
		logic rtc_long_interval_irq;     // Long real-time-clock interval
		logic power_switch_irq;          // Power switch
		logic battery_irq;               // Low battery
	} tlim_req_s;

	// Interrupt lines toward the CPU core
	typedef struct packed {
		logic cpu_irq_line0;             // Shared maskable line
		logic cpu_irq_line1;             // Long-interval timer line
		logic cpu_nmi;                   // Non-maskable interrupt
	} tlim_irq_s;

endpackage

`default_nettype wire

// ===== hw/tlim_top.sv
/*
 * Two-level interrupt masking and routing with an AXI4-Lite register slave.
 * Assumes one clock, synchronous active-low reset, and peripherals that hold
 * each request level until they clear the event themselves.
 */
`timescale 1ns/10ps
`default_nettype none

// Contract
// RULE_01: Serial status bits 13..6 show serial events
// RULE_02: Serial status bits 5..0 show character, DMA events
// RULE_03: Serial status is read-only, both serial units
// RULE_04: Reserved bits read zero; software writes zero
// RULE_05: System mask bits 13,12 enable suspend interrupts
// RULE_06: System mask bits 11..5 enable software, bus, units
// RULE_07: System mask bits 4..0 enable card, timers, power
// RULE_08: Touch mask writable bits 4..0 only
// RULE_09: Audio mask writable bits 3..0 only
// RULE_10: Keyboard mask writable bits 4..0 only
// RULE_11: GPIO mask bits 13, 11..0; bit 12 reserved
// RULE_12: Serial mask bits 13..0 match status bits
// RULE_13: Route bit 1 selects line0, 0 selects NMI
// RULE_14: Battery goes to NMI after reset
// RULE_15: Software bit write raises or clears request
// RULE_16: All masks reset to zero
// RULE_17: Processor unmasks needed sources, always battery
// RULE_18: Level-2 status ANDed with mask, ORed upward
// RULE_19: Level-1 status ANDed with level-1 mask
// RULE_20: Timer to line1, battery routed, rest line0
// RULE_21: Status follows request, reads never clear
// RULE_22: 16-bit registers, read-only writes ignored, combinational outputs
module tlim_top
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// AXI4-Lite write address
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Peripheral requests
	input wire tlim_pkg::tlim_req_s irq_req,
	// CPU core interrupt lines
	output tlim_pkg::tlim_irq_s irq_out
);

	// ==========================================================================
	// Byte addresses of the registers
	// ==========================================================================
	localparam logic [31:0] A_SER_STAT = 32'(tlim_pkg::IDX_SERIAL_IRQ_STATUS * tlim_pkg::ADDR_STRIDE);
	localparam logic [31:0] A_SYS_MASK = 32'(tlim_pkg::IDX_SYSTEM_IRQ_MASK * tlim_pkg::ADDR_STRIDE);
	localparam logic [31:0] A_TCH_MASK = 32'(tlim_pkg::IDX_TOUCH_IRQ_MASK * tlim_pkg::ADDR_STRIDE);
	localparam logic [31:0] A_AUD_MASK = 32'(tlim_pkg::IDX_AUDIO_IRQ_MASK * tlim_pkg::ADDR_STRIDE);
	localparam logic [31:0] A_KEY_MASK = 32'(tlim_pkg::IDX_KEYBOARD_IRQ_MASK * tlim_pkg::ADDR_STRIDE);
	localparam logic [31:0] A_GIO_MASK = 32'(tlim_pkg::IDX_GPIO_IRQ_MASK * tlim_pkg::ADDR_STRIDE);
	localparam logic [31:0] A_SER_MASK = 32'(tlim_pkg::IDX_SERIAL_IRQ_MASK * tlim_pkg::ADDR_STRIDE);
	localparam logic [31:0] A_ROUTE = 32'(tlim_pkg::IDX_BATTERY_IRQ_ROUTE * tlim_pkg::ADDR_STRIDE);
	localparam logic [31:0] A_SOFT = 32'(tlim_pkg::IDX_SOFTWARE_IRQ_SET * tlim_pkg::ADDR_STRIDE);

	// ==========================================================================
	// Register state
	// ==========================================================================
	logic [15:0] serial_irq_status_q;  // Sampled serial request levels
	logic [15:0] system_irq_mask_q;    // Level-1 enables
	logic [15:0] touch_irq_mask_q;     // Touch-panel enables
	logic [15:0] audio_irq_mask_q;     // Audio enables
	logic [15:0] keyboard_irq_mask_q;  // Keyboard enables
	logic [15:0] gpio_irq_mask_q;      // General I/O enables
	logic [15:0] serial_irq_mask_q;    // Serial enables
	logic [15:0] battery_irq_route_q;  // Battery route select in bit 0
	logic [15:0] software_irq_set_q;   // Software request in bit 0
	logic [15:0] system_irq_status;    // Level-1 status, combinational
	logic [15:0] system_enabled;       // Level-1 status after mask

	// Bus slave state
	logic aw_got_q;                    // Write address held
	logic w_got_q;                     // Write data held
	logic [31:0] awaddr_q;             // Held write address
	logic [31:0] wdata_q;              // Held write data
	logic [3:0] wstrb_q;               // Held byte strobes
	logic bvalid_q;                    // Write response pending
	logic [1:0] bresp_q;               // Write response code
	logic rvalid_q;                    // Read data pending
	logic [1:0] rresp_q;               // Read response code
	logic [31:0] rdata_q;              // Read data
	logic do_write;                    // Both halves of a write present
	logic wr_hit;                      // Write address is mapped
	logic [15:0] rd_value;             // Read mux output
	logic rd_hit;                      // Read address is mapped

	// Merges a strobed write into a register, touching only implemented bits
	function automatic logic [15:0] merge_write
	(
		input logic [15:0] old_val,
		input logic [31:0] wdata,
		input logic [3:0] wstrb,
		input logic [15:0] impl
	);
		logic [15:0] lanes;
		lanes = {{8{wstrb[1]}}, {8{wstrb[0]}}} & impl;
		merge_write = (old_val & ~lanes) | (wdata[15:0] & lanes);
	endfunction

	// ==========================================================================
	// Write channel
	// ==========================================================================
	assign s_axi_awready = !aw_got_q && !bvalid_q;
	assign s_axi_wready = !w_got_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign do_write = aw_got_q && w_got_q && !bvalid_q;

	// Write address decode
	always_comb
	begin
		case (awaddr_q)
			A_SER_STAT, A_SYS_MASK, A_TCH_MASK, A_AUD_MASK, A_KEY_MASK,
			A_GIO_MASK, A_SER_MASK, A_ROUTE, A_SOFT: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Capture write address and data in either order
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 32'h00000000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end
		else
		begin
			// Address taken
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			else if (do_write)
				aw_got_q <= 1'b0;
			// Data taken
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			else if (do_write)
				w_got_q <= 1'b0;
		end
	end

	// Write response, error for an unmapped address
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= tlim_pkg::RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? tlim_pkg::RESP_OKAY : tlim_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	// ==========================================================================
	// Mask, route and software registers
	// ==========================================================================
	// Only implemented bits take a write; status writes are dropped
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			system_irq_mask_q <= tlim_pkg::RESET_VALUE;    // see RULE_16
			touch_irq_mask_q <= tlim_pkg::RESET_VALUE;
			audio_irq_mask_q <= tlim_pkg::RESET_VALUE;
			keyboard_irq_mask_q <= tlim_pkg::RESET_VALUE;
			gpio_irq_mask_q <= tlim_pkg::RESET_VALUE;
			serial_irq_mask_q <= tlim_pkg::RESET_VALUE;
			battery_irq_route_q <= tlim_pkg::RESET_VALUE;  // see RULE_14
			software_irq_set_q <= tlim_pkg::RESET_VALUE;
		end
		else if (do_write)
		begin
			case (awaddr_q)
				// Level-1 enables
				A_SYS_MASK: system_irq_mask_q <= merge_write(system_irq_mask_q, wdata_q,
					wstrb_q, tlim_pkg::BITS_SYSTEM);  // see RULE_05 see RULE_06 see RULE_07
				// Level-2 enables
				A_TCH_MASK: touch_irq_mask_q <= merge_write(touch_irq_mask_q, wdata_q,
					wstrb_q, tlim_pkg::BITS_TOUCH);  // see RULE_08
				A_AUD_MASK: audio_irq_mask_q <= merge_write(audio_irq_mask_q, wdata_q,
					wstrb_q, tlim_pkg::BITS_AUDIO);  // see RULE_09
				A_KEY_MASK: keyboard_irq_mask_q <= merge_write(keyboard_irq_mask_q, wdata_q,
					wstrb_q, tlim_pkg::BITS_KEYBOARD);  // see RULE_10
				A_GIO_MASK: gpio_irq_mask_q <= merge_write(gpio_irq_mask_q, wdata_q,
					wstrb_q, tlim_pkg::BITS_GPIO);  // see RULE_11
				A_SER_MASK: serial_irq_mask_q <= merge_write(serial_irq_mask_q, wdata_q,
					wstrb_q, tlim_pkg::BITS_SERIAL);  // see RULE_12
				// Battery route select
				A_ROUTE: battery_irq_route_q <= merge_write(battery_irq_route_q, wdata_q,
					wstrb_q, tlim_pkg::BITS_ROUTE);  // see RULE_13
				// Software request set or clear
				A_SOFT: software_irq_set_q <= merge_write(software_irq_set_q, wdata_q,
					wstrb_q, tlim_pkg::BITS_SOFT);  // see RULE_15
				// Status and unmapped addresses change nothing
				default:
				begin
				end
			endcase
		end
	end

	// ==========================================================================
	// Serial status
	// ==========================================================================
	// Follows the request levels of both serial units; reading never clears
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			serial_irq_status_q <= tlim_pkg::RESET_VALUE;
		else
			serial_irq_status_q <= {2'b00, irq_req.serial} & tlim_pkg::BITS_SERIAL;  // see RULE_01 see RULE_02 see RULE_03 see RULE_21
	end

	// ==========================================================================
	// Level-1 status and routing
	// ==========================================================================
	// Each unit's enabled level-2 bits fold into one level-1 bit
	always_comb
	begin
		system_irq_status = 16'h0000;
		system_irq_status[tlim_pkg::L1_TOUCH_SUSPEND] = irq_req.touch_suspend_irq;
		system_irq_status[tlim_pkg::L1_KEYBOARD_SUSPEND] = irq_req.keyboard_suspend_irq;
		system_irq_status[tlim_pkg::L1_SOFTWARE] = software_irq_set_q[0];  // see RULE_15
		system_irq_status[tlim_pkg::L1_BUS_ERROR] = irq_req.bus_error_irq;
		system_irq_status[tlim_pkg::L1_SERIAL] = |(serial_irq_status_q & serial_irq_mask_q);  // see RULE_18
		system_irq_status[tlim_pkg::L1_GPIO] = |({2'b00, irq_req.gpio} & gpio_irq_mask_q);  // see RULE_18
		system_irq_status[tlim_pkg::L1_KEYBOARD] = |({11'h000, irq_req.keyboard} & keyboard_irq_mask_q);
		system_irq_status[tlim_pkg::L1_AUDIO] = |({12'h000, irq_req.audio} & audio_irq_mask_q);
		system_irq_status[tlim_pkg::L1_TOUCH] = |({11'h000, irq_req.touch} & touch_irq_mask_q);
		system_irq_status[tlim_pkg::L1_PC_CARD] = irq_req.pc_card_irq;
		system_irq_status[tlim_pkg::L1_EXT_TIMER] = irq_req.extended_timer_irq;
		system_irq_status[tlim_pkg::L1_RTC_LONG] = irq_req.rtc_long_interval_irq;
		system_irq_status[tlim_pkg::L1_POWER] = irq_req.power_switch_irq;
		system_irq_status[tlim_pkg::L1_BATTERY] = irq_req.battery_irq;
	end

	// Only enabled level-1 requests go on
	assign system_enabled = system_irq_status & system_irq_mask_q;  // see RULE_19

	// Long-interval timer to line1, battery by route, all others shared on line0
	always_comb
	begin
		irq_out.cpu_irq_line1 = system_enabled[tlim_pkg::L1_RTC_LONG];  // see RULE_20
		irq_out.cpu_nmi = system_enabled[tlim_pkg::L1_BATTERY] && !battery_irq_route_q[0];  // see RULE_13
		irq_out.cpu_irq_line0 = |(system_enabled & ~(16'h0001 << tlim_pkg::L1_RTC_LONG)
			& ~(16'h0001 << tlim_pkg::L1_BATTERY))
			|| (system_enabled[tlim_pkg::L1_BATTERY] && battery_irq_route_q[0]);  // see RULE_20 see RULE_22
	end

	// ==========================================================================
	// Read channel
	// ==========================================================================
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// Read mux, unimplemented bits are zero by construction
	always_comb
	begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			A_SER_STAT: rd_value = serial_irq_status_q;  // see RULE_03
			A_SYS_MASK: rd_value = system_irq_mask_q;
			A_TCH_MASK: rd_value = touch_irq_mask_q;
			A_AUD_MASK: rd_value = audio_irq_mask_q;
			A_KEY_MASK: rd_value = keyboard_irq_mask_q;
			A_GIO_MASK: rd_value = gpio_irq_mask_q;
			A_SER_MASK: rd_value = serial_irq_mask_q;
			A_ROUTE: rd_value = battery_irq_route_q;
			A_SOFT: rd_value = software_irq_set_q;
			default:
			begin
				rd_value = 16'h0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read data register, upper half reads zero
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= tlim_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= {16'h0000, rd_value};  // see RULE_04 see RULE_22
			rresp_q <= rd_hit ? tlim_pkg::RESP_OKAY : tlim_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// ==========================================================================
	// Assertions
	// ==========================================================================
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	// Address and data of a write both held
	sequence s_write_ready;
		aw_got_q && w_got_q && !bvalid_q;
	endsequence

	// Serial status tracks request one cycle later
	property p_serial_status;
		##1 serial_irq_status_q == {2'b00, $past(irq_req.serial)};
	endproperty
	a_serial_status: assert property (p_serial_status)  // see RULE_01
		else $error("serial status does not follow request");

	// Reserved bits never set in the system, touch, audio, keyboard, GPIO masks or route; upper read half zero
	property p_reserved_zero;
		((system_irq_mask_q & ~tlim_pkg::BITS_SYSTEM) == 16'h0000)
		&& ((gpio_irq_mask_q & ~tlim_pkg::BITS_GPIO) == 16'h0000)
		&& ((touch_irq_mask_q & ~tlim_pkg::BITS_TOUCH) == 16'h0000)
		&& ((audio_irq_mask_q & ~tlim_pkg::BITS_AUDIO) == 16'h0000)
		&& ((keyboard_irq_mask_q & ~tlim_pkg::BITS_KEYBOARD) == 16'h0000)
		&& ((battery_irq_route_q & ~tlim_pkg::BITS_ROUTE) == 16'h0000)
		&& (!rvalid_q || s_axi_rdata[31:16] == 16'h0000);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)  // see RULE_04
		else $error("reserved bit reads nonzero");

	// System and serial masks and route are clear, line0 low, on the first cycle after reset
	property p_mask_reset;
		$past(!reset_n) |-> (system_irq_mask_q == 16'h0000) && (serial_irq_mask_q == 16'h0000)
			&& (battery_irq_route_q == 16'h0000) && !irq_out.cpu_irq_line0;
	endproperty
	a_mask_reset: assert property (p_mask_reset)  // see RULE_16
		else $error("mask not zero after reset");

	// Line1 is exactly the enabled timer request
	property p_line1;
		irq_out.cpu_irq_line1 == (irq_req.rtc_long_interval_irq
			&& system_irq_mask_q[tlim_pkg::L1_RTC_LONG]);
	endproperty
	a_line1: assert property (p_line1)  // see RULE_20
		else $error("line1 mismatch");

	// Enabled battery with route clear reaches NMI, never line0 alone
	property p_battery_nmi;
		(irq_req.battery_irq && system_irq_mask_q[tlim_pkg::L1_BATTERY] && !battery_irq_route_q[0])
			|-> irq_out.cpu_nmi;
	endproperty
	a_battery_nmi: assert property (p_battery_nmi)  // see RULE_13
		else $error("battery not on NMI");

	// Routed battery never on NMI
	property p_battery_line0;
		battery_irq_route_q[0] |-> !irq_out.cpu_nmi
			&& (!(irq_req.battery_irq && system_irq_mask_q[tlim_pkg::L1_BATTERY])
			|| irq_out.cpu_irq_line0);
	endproperty
	a_battery_line0: assert property (p_battery_line0)  // see RULE_14
		else $error("routed battery misdirected");

	// Software bit write of 1 raises enabled line0 on the next cycle
	property p_soft_raise;
		(s_write_ready and (awaddr_q == A_SOFT) && wstrb_q[0] && wdata_q[0]
			&& system_irq_mask_q[tlim_pkg::L1_SOFTWARE])
			##1 system_irq_mask_q[tlim_pkg::L1_SOFTWARE] |-> irq_out.cpu_irq_line0;
	endproperty
	a_soft_raise: assert property (p_soft_raise)  // see RULE_15
		else $error("software request did not raise line0");

	// Software bit changes only by its own register write, not across reset release
	property p_soft_only_write;
		$past(reset_n) && $changed(software_irq_set_q) |-> $past(do_write)
			&& ($past(awaddr_q) == A_SOFT);
	endproperty
	a_soft_only_write: assert property (p_soft_only_write)  // see RULE_15
		else $error("software bit changed without write");

	// Masked serial event never reaches level-1
	property p_serial_fold;
		system_irq_status[tlim_pkg::L1_SERIAL] == |(serial_irq_status_q & serial_irq_mask_q);
	endproperty
	a_serial_fold: assert property (p_serial_fold)  // see RULE_18
		else $error("serial level-1 bit wrong");

	// Level-1 masked sources stay off line0
	property p_line0_masked;
		(system_irq_mask_q == 16'h0000) |-> !irq_out.cpu_irq_line0 && !irq_out.cpu_nmi;
	endproperty
	a_line0_masked: assert property (p_line0_masked)  // see RULE_19
		else $error("masked request reached CPU");

	// Write answers the cycle after both halves are held
	property p_write_resp;
		s_write_ready |-> ##1 s_axi_bvalid;
	endproperty
	a_write_resp: assert property (p_write_resp)  // see RULE_22
		else $error("write response late");

	// Read answers on the next cycle, error when unmapped
	property p_read_resp;
		(s_axi_arvalid && s_axi_arready && !rd_hit) |=> s_axi_rvalid
			&& (s_axi_rresp == tlim_pkg::RESP_SLVERR);
	endproperty
	a_read_resp: assert property (p_read_resp)  // see RULE_22
		else $error("unmapped read not refused");

endmodule // tlim_top

`default_nettype wire

// ===== bench/tlim_periph.sv
/* Peripheral request model for the two-level interrupt block.
 * Assumes the bench sets the wanted request levels. */
`timescale 1ns/10ps
`default_nettype none
module tlim_periph
(
	// Clock, reset and wanted levels
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire tlim_pkg::tlim_req_s want,
	// Levels toward the block
	output tlim_pkg::tlim_req_s irq_req
);
	// Units hold each level until they clear the event
	always_ff @(posedge clk_sys)
		if (!reset_n)
			irq_req <= '0;
		else
			irq_req <= want;
endmodule // tlim_periph
`default_nettype wire

// ===== bench/tb.sv
/* Self-checking bench of the two-level interrupt block.
 * Assumes the design files and the peripheral model are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb;
	// ==========================================================
	// Signals and register tables
	// ==========================================================
	logic clk_sys = 1'h0, reset_n = 1'h0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	tlim_pkg::tlim_req_s want = '0, irq_req;
	tlim_pkg::tlim_irq_s irq_out;
	int n_fail = 0, comparisons = 0;
	localparam logic [31:0] RA [9] = '{tlim_pkg::IDX_SERIAL_IRQ_STATUS*4,
		tlim_pkg::IDX_SYSTEM_IRQ_MASK*4, tlim_pkg::IDX_TOUCH_IRQ_MASK*4,
		tlim_pkg::IDX_AUDIO_IRQ_MASK*4, tlim_pkg::IDX_KEYBOARD_IRQ_MASK*4,
		tlim_pkg::IDX_GPIO_IRQ_MASK*4, tlim_pkg::IDX_SERIAL_IRQ_MASK*4,
		tlim_pkg::IDX_BATTERY_IRQ_ROUTE*4, tlim_pkg::IDX_SOFTWARE_IRQ_SET*4};
	localparam logic [15:0] WM [9] = '{16'h3fff, 16'h3fff, 16'h001f, 16'h000f,
		16'h001f, 16'h2fff, 16'h3fff, 16'h0001, 16'h0001};
	// Design and peripheral model
	tlim_top i_tlim_top (.clk_sys, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_req, .irq_out);
	tlim_periph i_tlim_periph (.clk_sys, .reset_n, .want, .irq_req);
	always #20 clk_sys = ~clk_sys;
	// ==========================================================
	// Bus and compare tasks
	// ==========================================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic ci(input logic [2:0] e);
		@(negedge clk_sys);
		chk({29'h0, irq_out}, {29'h0, e});
	endtask
	// Ready sampled at the negedge equals its value at the next edge
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic ah, wh, bh;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(negedge clk_sys);
			{ah, wh, bh, rr} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
			@(posedge clk_sys);
			s_axi_awvalid <= s_axi_awvalid && !ah;
			s_axi_wvalid <= s_axi_wvalid && !wh;
		end
		while (!bh);
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [31:0] a);
		logic ah, rh;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(negedge clk_sys);
			{ah, rh, rv, rr} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge clk_sys);
			s_axi_arvalid <= s_axi_arvalid && !ah;
		end
		while (!rh);
		s_axi_rready <= 1'h0;
	endtask
	// ==========================================================
	// Scenarios
	// ==========================================================
	task automatic t_regs;
		for (int i = 0; i < 9; i++)
		begin
			rd(RA[i]);
			chk(rv, 32'h0);
			chk({30'h0, rr}, {30'h0, tlim_pkg::RESP_OKAY});
		end
		want <= '1;
		// Software keeps reserved bits at zero; the status gets zero as well
		for (int i = 0; i < 9; i++)
		begin
			wr(RA[i], i == 0 ? 32'h0 : {16'h0, WM[i]});
			chk({30'h0, rr}, {30'h0, tlim_pkg::RESP_OKAY});
			rd(RA[i]);
			chk(rv, {16'h0, WM[i]});
		end
		ci(3'b110);
		wr(RA[8] + 32'h8, 32'h1);
		chk({30'h0, rr}, {30'h0, tlim_pkg::RESP_SLVERR});
		rd(RA[8] + 32'h8);
		chk(rv, 32'h0);
		chk({30'h0, rr}, {30'h0, tlim_pkg::RESP_SLVERR});
	endtask
	// One level-1 enable at a time, every source but software requesting
	task automatic t_walk;
		wr(RA[8], 32'h0);
		wr(RA[7], 32'h0);
		for (int b = 0; b < 14; b++)
		begin
			wr(RA[1], 32'h1 << b);
			ci(b == 2 ? 3'b010 : b == 0 ? 3'b001 : b == 11 ? 3'b000 : 3'b100);
		end
		wr(RA[1], 32'h1);
		wr(RA[7], 32'h1);
		ci(3'b100);
		wr(RA[1], 32'h800);
		wr(RA[8], 32'h1);
		ci(3'b100);
		wr(RA[8], 32'h0);
		ci(3'b000);
	endtask
	task automatic t_serial;
		// Serial levels only, one assignment of the whole request word
		want <= {14'h2a55, 36'h0};
		repeat (4) @(posedge clk_sys);
		rd(RA[0]);
		chk(rv, 32'h2a55);
		rd(RA[0]);
		chk(rv, 32'h2a55);
		wr(RA[1], 32'h200);
		wr(RA[6], 32'h1000);
		ci(3'b000);
		wr(RA[6], 32'h2000);
		ci(3'b100);
		want <= '0;
		repeat (4) @(posedge clk_sys);
		ci(3'b000);
	endtask
	task automatic close_out;
		if (n_fail == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Main sequence after two reset cycles
	initial
	begin
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'h1;
		t_regs();
		t_walk();
		t_serial();
		close_out();
	end
	// Watchdog against a hung handshake
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		close_out();
	end
endmodule // tb
`default_nettype wire
